// ### core/iaor_pkg.sv
package iaor_pkg;
    // Sample width, FIFO depth and clock period
    localparam int SAMPLE_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_PERIOD_NS = 10;
    // Reset low time owed by the controlling party, in ns
    localparam int RST_MIN_NS = 200;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest configuration reload, in ms, and its cycle count
    localparam int RELOAD_MAX_MS = 87;
    localparam int RELOAD_MAX_CYC = (RELOAD_MAX_MS * 1000000) / CLK_PERIOD_NS;
    localparam int LOAD_W = 24;
    localparam logic [SAMPLE_W-1:0] SAMPLE_IDLE = 12'hFFF;
    typedef enum logic [1:0] {IAOR_BOOT, IAOR_HOLD, IAOR_LOAD, IAOR_RUN} iaor_state_t;
endpackage

// ### core/iaor_top.sv
`timescale 1ns/100ps
// Contract
// - Halve the sample clock; drive two channels with halves 180 degrees apart.
// - Two 12-bit output buses, each at half the conversion rate.
// - Output words are twos complement.
// - Each bus has a data-ready strobe for capture timing.
// - Configuration loads automatically at power-up before valid output.
// - Active-low reset input reloads the configuration.
// - During reset and reload all bus data and ready outputs are high.
// - Reload starts on the rising edge ending reset.
// - Reload completes within 87 ms, then output resumes.
// - Resumed data-ready toggling marks the end of reset.

// ==========================================
// Sample FIFO
module iaor_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // Clock and control
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             ce,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Depth check at elaboration
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
        $error("DEPTH must be a power of two");
    end

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rptr_r];

    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem_r[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else if (ce) begin
            if (push) wptr_r <= wptr_r + 1'b1;
            if (pop) rptr_r <= rptr_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    fifo_bound_a: assert property (@(posedge clk_sys) disable iff (srst)
        cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // iaor_fifo

// ==========================================
// Output and reload control
module iaor_top
    import iaor_pkg::*;
#(
    parameter int RELOAD_CYC = RELOAD_MAX_CYC
) (
    // Clock, enable, reset
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire logic                        ce,
    // Reset pin from the controlling party
    input  wire logic                        reset_n,
    // Samples from the conversion channels, one per clock
    input  wire logic [iaor_pkg::SAMPLE_W-1:0] conv_data,
    input  wire logic                        conv_valid,
    output logic                             conv_ready,
    // Channel clocks
    output logic                             chan_a_clk,
    output logic                             chan_b_clk,
    // Output buses
    output logic [iaor_pkg::SAMPLE_W-1:0]    bus_a_data,
    output logic                             bus_a_ready,
    output logic [iaor_pkg::SAMPLE_W-1:0]    bus_b_data,
    output logic                             bus_b_ready,
    // Status
    output logic                             reload_busy
);
    import iaor_pkg::*;

    if (RELOAD_CYC < 1 || RELOAD_CYC >= (1 << LOAD_W)) begin : g_reload_chk
        $error("RELOAD_CYC out of range");
    end

    iaor_state_t      state_r, state_nxt;
    logic [LOAD_W-1:0] load_cnt_r;
    logic             rst_n_d_r;
    logic             phase_r;
    logic             pair_r;
    logic [SAMPLE_W-1:0] hold_a_r;
    logic [SAMPLE_W-1:0] fifo_data;
    logic             fifo_valid;
    logic             fifo_ready;
    logic             fifo_in_ready;

    function automatic logic is_run(input iaor_state_t s);
        return (s == IAOR_RUN);
    endfunction

    wire rst_rise  = reset_n && !rst_n_d_r;
    wire load_done = (load_cnt_r == LOAD_W'(RELOAD_CYC - 1));
    wire running   = is_run(state_r);
    wire take      = running && fifo_valid;

    assign fifo_ready = running;

    // ==========================================
    // Reload sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            IAOR_BOOT: state_nxt = reset_n ? IAOR_LOAD : IAOR_HOLD;
            IAOR_HOLD: if (rst_rise) state_nxt = IAOR_LOAD;
            IAOR_LOAD: if (!reset_n) state_nxt = IAOR_HOLD;
                       else if (load_done) state_nxt = IAOR_RUN;
            IAOR_RUN:  if (!reset_n) state_nxt = IAOR_HOLD;
            default:   state_nxt = IAOR_BOOT;
        endcase
    end

    iaor_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst || (ce && !running)),
        .ce        (ce),
        .in_data   (conv_data),
        .in_valid  (conv_valid && conv_ready),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    // ==========================================
    // State and output registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r     <= IAOR_BOOT;
            load_cnt_r  <= '0;
            rst_n_d_r   <= 1'b1;
            phase_r     <= 1'b0;
            pair_r      <= 1'b0;
            hold_a_r    <= '0;
            chan_a_clk  <= 1'b0;
            chan_b_clk  <= 1'b1;
            bus_a_data  <= SAMPLE_IDLE;
            bus_b_data  <= SAMPLE_IDLE;
            bus_a_ready <= 1'b1;
            bus_b_ready <= 1'b1;
            reload_busy <= 1'b1;
            conv_ready  <= 1'b0;
        end else if (ce) begin
            state_r     <= state_nxt;
            rst_n_d_r   <= reset_n;
            reload_busy <= !is_run(state_nxt);
            conv_ready  <= is_run(state_nxt);
            load_cnt_r  <= (state_r == IAOR_LOAD) ? load_cnt_r + 1'b1 : '0;
            phase_r     <= ~phase_r;
            chan_a_clk  <= ~phase_r;
            chan_b_clk  <= phase_r;
            if (!is_run(state_nxt)) begin
                bus_a_data  <= SAMPLE_IDLE;
                bus_b_data  <= SAMPLE_IDLE;
                bus_a_ready <= 1'b1;
                bus_b_ready <= 1'b1;
                pair_r      <= 1'b0;
            end else if (take) begin
                pair_r <= ~pair_r;
                if (!pair_r) begin
                    hold_a_r <= fifo_data;
                end else begin
                    bus_a_data  <= hold_a_r;
                    bus_b_data  <= fifo_data;
                    bus_a_ready <= ~bus_a_ready;
                    bus_b_ready <= ~bus_b_ready;
                end
            end
        end
    end

    // ==========================================
    // Checks
    idle_high_a: assert property (@(posedge clk_sys) disable iff (srst)
        reload_busy |-> (bus_a_data == SAMPLE_IDLE && bus_b_data == SAMPLE_IDLE && bus_a_ready && bus_b_ready))
        else $error("outputs not high in reload");
    hold_no_load_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !reset_n && $past(ce) |=> state_r != IAOR_LOAD && state_r != IAOR_RUN)
        else $error("load while reset low");
    load_start_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && state_r == IAOR_HOLD && rst_rise |=> state_r == IAOR_LOAD)
        else $error("reload not started on reset rise");
    chan_anti_a: assert property (@(posedge clk_sys) disable iff (srst)
        chan_a_clk != chan_b_clk) else $error("channel clocks not in antiphase");
    chan_half_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce |=> chan_a_clk != $past(chan_a_clk)) else $error("channel clock not halved");
    strobe_pair_a: assert property (@(posedge clk_sys) disable iff (srst)
        !reload_busy && $changed(bus_a_ready) |-> $changed(bus_b_ready)) else $error("strobes out of step");
    ready_stand_a: assert property (@(posedge clk_sys) disable iff (srst)
        running && reset_n && !(take && pair_r) |=> $stable(bus_a_ready) && $stable(bus_b_ready))
        else $error("strobe moved without a pair");
    fifo_room_a: assert property (@(posedge clk_sys) disable iff (srst)
        conv_ready |-> fifo_in_ready) else $error("sample accepted without fifo room");
    load_bound_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_r == IAOR_LOAD |-> load_cnt_r < LOAD_W'(RELOAD_CYC)) else $error("reload overran");
endmodule // iaor_top

// ### testbench/iaor_cap.sv
`timescale 1ns/100ps
// ==========================================
// Capture logic beyond the output buses
module iaor_cap (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                srst,
    // Buses from the device
    input  wire logic [iaor_pkg::SAMPLE_W-1:0]       bus_a_data,
    input  wire logic                                bus_a_ready,
    input  wire logic [iaor_pkg::SAMPLE_W-1:0]       bus_b_data,
    input  wire logic                                reload_busy,
    // Last four captured pairs
    output logic      [3:0][iaor_pkg::SAMPLE_W-1:0]  cap_a,
    output logic      [3:0][iaor_pkg::SAMPLE_W-1:0]  cap_b,
    output logic      [7:0]                          cap_cnt
);
    import iaor_pkg::*;
    logic rdy_r;
    // Take a pair on each strobe flip, ignore reload time
    always @(posedge clk_sys) begin
        if (srst) begin
            cap_cnt <= 8'h00;
            rdy_r   <= 1'b1;
        end else begin
            rdy_r <= bus_a_ready;
            if (!reload_busy && bus_a_ready != rdy_r) begin
                cap_a[cap_cnt[1:0]] <= bus_a_data;
                cap_b[cap_cnt[1:0]] <= bus_b_data;
                cap_cnt <= cap_cnt + 8'h01;
            end
        end
    end
endmodule // iaor_cap

// ### testbench/interleaved_adc_output_reset_tb.sv
`timescale 1ns/100ps
module interleaved_adc_output_reset_tb;
    import iaor_pkg::*;
    localparam int RC = 20;
    // Watchdog span, well past two reloads and the traffic
    localparam int WD_CYC = 10 * RC + 200;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic reset_n = 1'b1;
    logic [SAMPLE_W-1:0] conv_data = 12'h000;
    logic conv_valid = 1'b0;
    wire conv_ready, chan_a_clk, chan_b_clk, bus_a_ready, bus_b_ready, reload_busy;
    wire [SAMPLE_W-1:0] bus_a_data, bus_b_data;
    wire [3:0][SAMPLE_W-1:0] cap_a, cap_b;
    wire [7:0] cap_cnt;
    int error_cnt = 0;
    int n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    iaor_top #(.RELOAD_CYC(RC)) DUT (.clk_sys(clk_sys), .srst(srst), .ce(ce), .reset_n(reset_n),
        .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready), .chan_a_clk(chan_a_clk),
        .chan_b_clk(chan_b_clk), .bus_a_data(bus_a_data), .bus_a_ready(bus_a_ready),
        .bus_b_data(bus_b_data), .bus_b_ready(bus_b_ready), .reload_busy(reload_busy));
    iaor_cap CAP (.clk_sys(clk_sys), .srst(srst), .bus_a_data(bus_a_data), .bus_a_ready(bus_a_ready),
        .bus_b_data(bus_b_data), .reload_busy(reload_busy), .cap_a(cap_a), .cap_b(cap_b), .cap_cnt(cap_cnt));
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Reload must last RC-2 cycles, then end within a few cycles
    task automatic wait_run;
        int i;
        repeat (RC - 2) @(negedge clk_sys);
        check({reload_busy, bus_a_data, bus_b_data, bus_a_ready, bus_b_ready}, 27'h7FFFFFF);
        check(conv_ready, 1'b0);
        for (i = 0; i < 8 && reload_busy !== 1'b0; i++) @(negedge clk_sys);
        check({reload_busy, conv_ready}, 2'b01);
    endtask
    task automatic send(input logic [SAMPLE_W-1:0] w);
        int i;
        conv_data = w;
        conv_valid = 1'b1;
        for (i = 0; i < 50 && conv_ready !== 1'b1; i++) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic t_boot;
        srst = 1'b0;
        @(negedge clk_sys);
        wait_run();
    endtask
    // Enable low freezes channel clocks and run state
    task automatic t_freeze;
        logic c;
        c = chan_a_clk;
        ce = 1'b0;
        repeat (3) @(negedge clk_sys);
        check({chan_a_clk, chan_b_clk, reload_busy, conv_ready}, {c, ~c, 2'b01});
        ce = 1'b1;
    endtask
    // Extreme and near-zero signed words back to back; split by parity
    task automatic t_pairs;
        logic [7:0] n;
        logic c;
        n = cap_cnt;
        c = chan_a_clk;
        @(negedge clk_sys);
        check({chan_a_clk, chan_b_clk}, {~c, c});
        send(12'h800);
        send(12'h7FF);
        send(12'h001);
        send(12'hFFE);
        conv_valid = 1'b0;
        repeat (8) @(negedge clk_sys);
        check(cap_cnt, n + 8'h02);
        check({cap_a[n[1:0]], cap_b[n[1:0]]}, 24'h8007FF);
        check({cap_a[n[1:0] + 2'h1], cap_b[n[1:0] + 2'h1]}, 24'h001FFE);
        check({bus_a_ready, bus_b_ready, bus_a_data, bus_b_data}, 26'h3001FFE);
    endtask
    // Reset pin with an unpaired word in flight
    task automatic t_reset;
        logic [7:0] n;
        send(12'h123);
        conv_valid = 1'b0;
        reset_n = 1'b0;
        repeat (RST_MIN_CYC) @(negedge clk_sys);
        check({reload_busy, bus_a_data, bus_b_data, bus_a_ready, bus_b_ready}, 27'h7FFFFFF);
        reset_n = 1'b1;
        @(negedge clk_sys);
        wait_run();
        n = cap_cnt;
        send(12'hABC);
        send(12'h456);
        conv_valid = 1'b0;
        repeat (8) @(negedge clk_sys);
        check({cap_cnt, cap_a[n[1:0]], cap_b[n[1:0]]}, {n + 8'h01, 24'hABC456});
        check({bus_a_ready, bus_b_ready}, 2'b00);
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        t_boot();
        t_freeze();
        t_pairs();
        t_reset();
        print_verdict();
    end
    initial begin
        repeat (WD_CYC) @(negedge clk_sys);
        error_cnt++;
        print_verdict();
    end
endmodule // interleaved_adc_output_reset_tb
